// *** core/hca_pkg.sv ***
package hca_pkg;

	// Current and threshold scaling: one code step is 0.1 A
	localparam int              HCA_CUR_W        = 16;
	localparam int              HCA_THR_W        = 10;
	localparam int              HCA_NCH          = 2;
	localparam logic [9:0]      HCA_THR_ZERO     = 10'h000;  // 0.0 A
	localparam logic [9:0]      HCA_THR_MIN      = 10'h001;  // 0.1 A
	localparam logic [9:0]      HCA_THR_MAX      = 10'h1F3;  // 49.9 A
	localparam logic [9:0]      HCA_THR_FULL     = 10'h1F4;  // 50.0 A
	localparam logic [15:0]     HCA_SAT_LIMIT    = 16'h0226; // 55.0 A
	localparam logic [15:0]     HCA_SAT_CODE     = 16'hFFFF;

	// Password -169 in two's complement
	localparam logic [15:0]     HCA_PASSWORD     = 16'hFF57;

	// Alarm enables after reset: all three on
	localparam logic [2:0]      HCA_EN_RESET     = 3'h7;

	// Timing, in milliseconds, and the millisecond tick
	localparam int              HCA_CLK_HZ       = 40_000_000;
	localparam int              HCA_TICK_MS      = 1;
	localparam int              HCA_TICK_CYCLES  = HCA_CLK_HZ / 1000 * HCA_TICK_MS;
	localparam int              HCA_MIN_PULSE_MS = 100;
	localparam int              HCA_LONG_HOLD_MS = 3000;
	localparam int              HCA_STEP_HOLD_MS = 1000;
	localparam int              HCA_SHORT_MS     = 1000;
	localparam int              HCA_MS_W         = 12;

	typedef enum logic [1:0] {
		HCA_OPER,
		HCA_ADJ,
		HCA_INIT,
		HCA_ADV
	} hca_level_t;

	typedef struct packed {
		logic [9:0] open_thr;
		logic [9:0] short_thr;
		logic [9:0] oc_thr;
	} hca_thr_t;

	typedef struct packed {
		logic heater_open_alarm;
		logic heater_short_alarm;
		logic heater_overcurrent_alarm;
	} hca_alm_t;

	// Monitor code: a current above 55.0 A shows the saturated code
	function automatic logic [15:0] hca_sat(input logic [15:0] cur);
		hca_sat = (cur > HCA_SAT_LIMIT) ? HCA_SAT_CODE : cur;
	endfunction

endpackage

// *** core/hca_chan.sv ***
`timescale 1ns/10ps
module hca_chan
	import hca_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic        sample_in,
	input  wire logic        heat_on_in,
	input  wire logic        on_ok_in,
	input  wire logic        off_ok_in,
	input  wire logic [15:0] cur_in,
	input  wire hca_thr_t    thr_in,
	input  wire hca_alm_t    en_in,
	output hca_alm_t         alm_out,
	output logic      [15:0] heat_mon_out,
	output logic      [15:0] leak_mon_out
);

	hca_alm_t    alm_q, alm_d;
	logic [15:0] hmon_q, hmon_d, lmon_q, lmon_d;
	logic        smp_on, smp_off;
	logic [15:0] thr_open, thr_short, thr_oc;

	assign smp_on    = sample_in && heat_on_in;
	assign smp_off   = sample_in && !heat_on_in;
	assign thr_open  = {6'h00, thr_in.open_thr};
	assign thr_short = {6'h00, thr_in.short_thr};
	assign thr_oc    = {6'h00, thr_in.oc_thr};

	// Alarm evaluation; a forced threshold wins over any sample, an unqualified sample keeps the last verdict
	always_comb begin
		alm_d  = alm_q;
		hmon_d = hmon_q;
		lmon_d = lmon_q;
		if (smp_on) hmon_d = hca_sat(cur_in);
		if (smp_off) lmon_d = hca_sat(cur_in);
		if (!en_in.heater_open_alarm) alm_d.heater_open_alarm = 1'b0;
		else if (thr_in.open_thr == HCA_THR_ZERO) alm_d.heater_open_alarm = 1'b0;
		else if (thr_in.open_thr >= HCA_THR_FULL) alm_d.heater_open_alarm = 1'b1;
		else if (smp_on && on_ok_in) alm_d.heater_open_alarm = (cur_in < thr_open);
		if (!en_in.heater_short_alarm) alm_d.heater_short_alarm = 1'b0;
		else if (thr_in.short_thr == HCA_THR_ZERO) alm_d.heater_short_alarm = 1'b1;
		else if (thr_in.short_thr >= HCA_THR_FULL) alm_d.heater_short_alarm = 1'b0;
		else if (smp_off && off_ok_in) alm_d.heater_short_alarm = (cur_in > thr_short);
		if (!en_in.heater_overcurrent_alarm) alm_d.heater_overcurrent_alarm = 1'b0;
		else if (thr_in.oc_thr == HCA_THR_ZERO) alm_d.heater_overcurrent_alarm = 1'b1;
		else if (thr_in.oc_thr >= HCA_THR_FULL) alm_d.heater_overcurrent_alarm = 1'b0;
		else if (smp_on && on_ok_in) alm_d.heater_overcurrent_alarm = (cur_in > thr_oc);
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			alm_q  <= '0;
			hmon_q <= 16'h0000;
			lmon_q <= 16'h0000;
		end else begin
			alm_q  <= alm_d;
			hmon_q <= hmon_d;
			lmon_q <= lmon_d;
		end
	end

	assign alm_out      = alm_q;
	assign heat_mon_out = hmon_q;
	assign leak_mon_out = lmon_q;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	property p_sat;
		smp_on && (cur_in > HCA_SAT_LIMIT) |=> (hmon_q == HCA_SAT_CODE);
	endproperty
	a_sat: assert property (p_sat) else $error("monitor not saturated");

	property p_force0;
		(thr_in.open_thr == HCA_THR_ZERO) && (thr_in.short_thr == HCA_THR_ZERO) && en_in.heater_short_alarm
			|=> !alm_q.heater_open_alarm && alm_q.heater_short_alarm;
	endproperty
	a_force0: assert property (p_force0) else $error("zero threshold not forced");

	property p_force50;
		(thr_in.oc_thr == HCA_THR_FULL) && (thr_in.open_thr == HCA_THR_FULL) && en_in.heater_open_alarm
			|=> alm_q.heater_open_alarm && !alm_q.heater_overcurrent_alarm;
	endproperty
	a_force50: assert property (p_force50) else $error("full threshold not forced");

	property p_open_det;
		smp_on && on_ok_in && en_in.heater_open_alarm && (thr_in.open_thr >= HCA_THR_MIN)
			&& (thr_in.open_thr <= HCA_THR_MAX) |=> (alm_q.heater_open_alarm == $past(cur_in < thr_open));
	endproperty
	a_open_det: assert property (p_open_det) else $error("open verdict wrong");

	property p_short_hold;
		smp_off && !off_ok_in && en_in.heater_short_alarm && (thr_in.short_thr >= HCA_THR_MIN)
			&& (thr_in.short_thr <= HCA_THR_MAX) && $stable(en_in) |=> $stable(alm_q.heater_short_alarm);
	endproperty
	a_short_hold: assert property (p_short_hold) else $error("short checked on brief off");

	property p_open_en;
		!en_in.heater_open_alarm |=> !alm_q.heater_open_alarm;
	endproperty
	a_open_en: assert property (p_open_en) else $error("disabled open alarm active");

	c_open: cover property (smp_on && on_ok_in ##1 alm_q.heater_open_alarm);
	c_short: cover property (smp_off && off_ok_in ##1 alm_q.heater_short_alarm);

endmodule // hca_chan

// *** core/hca_top.sv ***
`timescale 1ns/10ps
// Function
// - Thresholds from 0.1 A to 49.9 A give normal detection.
// - Threshold 0.0: open alarm off, short and overcurrent alarms on.
// - Threshold 50.0: open alarm on, short and overcurrent alarms off.
// - Current above 55.0 A reads as monitor code FFFF.
// - Open alarm works only when enabled; one threshold per channel.
// - Open alarm enable resets to on.
// - Short alarm works only when enabled; one threshold per channel.
// - Short alarm enable resets to on.
// - Overcurrent alarm works only when enabled; one threshold per channel.
// - Overcurrent alarm enable resets to on.
// - Level key held three seconds in operation level enters initial setting level.
// - Advanced level entered from initial level only with password -169.
// - One-second holds step advanced to initial, then initial to operation.
// - Two short presses move operation level to adjustment level.
// - Heating on: current below open threshold raises open alarm.
// - Heating off: leakage above short threshold raises short alarm.
// - On or off times of 100 ms or less skip detection.
// - First alarm output ORs alarm 1 function with the three heater alarms.
module hca_top
	import hca_pkg::*;
#(
	parameter int TICK_CYCLES  = HCA_TICK_CYCLES,
	parameter int MIN_PULSE_MS = HCA_MIN_PULSE_MS,
	parameter int LONG_HOLD_MS = HCA_LONG_HOLD_MS,
	parameter int STEP_HOLD_MS = HCA_STEP_HOLD_MS,
	parameter int SHORT_MS     = HCA_SHORT_MS
) (
	input  wire logic                    clk_in,
	input  wire logic                    rstn_in,
	input  wire logic                    level_key_in,
	input  wire logic                    pw_valid_in,
	input  wire logic [15:0]             pw_value_in,
	input  wire logic                    en_wr_in,
	input  wire hca_alm_t                en_data_in,
	input  wire logic                    heat_in,
	input  wire logic                    first_alarm_output_func_in,
	input  wire logic                    sample_in,
	input  wire logic [HCA_NCH-1:0][15:0] cur_in,
	input  wire hca_thr_t [HCA_NCH-1:0]  thr_in,
	output hca_level_t                   level_out,
	output hca_alm_t                     en_out,
	output hca_alm_t                     alarm_out,
	output logic                         first_alarm_output_out,
	output logic [HCA_NCH-1:0][15:0]     heat_mon_out,
	output logic [HCA_NCH-1:0][15:0]     leak_mon_out
);

	localparam int TW = $clog2(TICK_CYCLES + 1);

	logic                    key_m_q, key_s_q, key_p_q;
	logic [TW-1:0]           tick_q, tick_d;
	logic                    tick;
	logic [HCA_MS_W-1:0]     hold_q, hold_d, pulse_q, pulse_d;
	logic                    armed_q, armed_d, shorts_q, shorts_d, heat_q;
	logic                    short_evt, long_go, step_go, pw_ok, on_ok, off_ok;
	hca_level_t              level_q, level_d;
	hca_alm_t                en_q, en_d, alm_q, alm_d;
	logic                    first_q, first_d;
	hca_alm_t [HCA_NCH-1:0]  ch_alm;

	// Key pin synchroniser; only key_s_q and later stages feed logic
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			key_m_q <= 1'b0;
			key_s_q <= 1'b0;
		end else begin
			key_m_q <= level_key_in;
			key_s_q <= key_m_q;
		end
	end

	// Millisecond tick divider and the two millisecond counters
	always_comb begin
		tick   = (tick_q == TW'(TICK_CYCLES - 1));
		tick_d = tick ? '0 : tick_q + TW'(1);
		hold_d = hold_q;
		if (!key_s_q) hold_d = '0;
		else if (tick && hold_q != '1) hold_d = hold_q + HCA_MS_W'(1);
		pulse_d = pulse_q;
		if (heat_in != heat_q) pulse_d = '0;
		else if (tick && pulse_q <= HCA_MS_W'(MIN_PULSE_MS)) pulse_d = pulse_q + HCA_MS_W'(1);
	end

	// Skip detection until the current on or off interval passes 100 ms
	assign on_ok  = heat_in && (pulse_q > HCA_MS_W'(MIN_PULSE_MS));
	assign off_ok = !heat_in && (pulse_q > HCA_MS_W'(MIN_PULSE_MS));

	// Key gestures; a long hold disarms until release so one hold steps only one level
	assign short_evt = key_p_q && !key_s_q && armed_q && (hold_q < HCA_MS_W'(SHORT_MS));
	assign long_go   = armed_q && key_s_q && (hold_q >= HCA_MS_W'(LONG_HOLD_MS));
	assign step_go   = armed_q && key_s_q && (hold_q >= HCA_MS_W'(STEP_HOLD_MS));
	assign pw_ok     = pw_valid_in && (pw_value_in == HCA_PASSWORD);

	// Setting level machine
	always_comb begin
		level_d = level_q;
		case (level_q)
			HCA_OPER: begin
				if (long_go) level_d = HCA_INIT;
				else if (short_evt && shorts_q) level_d = HCA_ADJ;
			end
			HCA_ADJ: begin
				if (short_evt && shorts_q) level_d = HCA_OPER;
			end
			HCA_INIT: begin
				if (step_go) level_d = HCA_OPER;
				else if (pw_ok) level_d = HCA_ADV;
			end
			HCA_ADV: begin
				if (step_go) level_d = HCA_INIT;
			end
			default: level_d = HCA_OPER;
		endcase
		armed_d = armed_q;
		if (level_d != level_q && key_s_q) armed_d = 1'b0;
		else if (!key_s_q) armed_d = 1'b1;
		shorts_d = shorts_q;
		if (level_d != level_q || (key_s_q && hold_q >= HCA_MS_W'(SHORT_MS))) shorts_d = 1'b0;
		else if (short_evt) shorts_d = 1'b1;
	end

	// Enables change only in the advanced level, so a stray write elsewhere is ignored
	always_comb begin
		en_d = en_q;
		if (en_wr_in && level_q == HCA_ADV) en_d = en_data_in;
	end

	// One evaluator per current channel
	for (genvar g = 0; g < HCA_NCH; g++) begin : g_ch
		hca_chan u_chan (
			.clk_in       (clk_in),
			.rstn_in      (rstn_in),
			.sample_in    (sample_in),
			.heat_on_in   (heat_in),
			.on_ok_in     (on_ok),
			.off_ok_in    (off_ok),
			.cur_in       (cur_in[g]),
			.thr_in       (thr_in[g]),
			.en_in        (en_q),
			.alm_out      (ch_alm[g]),
			.heat_mon_out (heat_mon_out[g]),
			.leak_mon_out (leak_mon_out[g])
		);
	end

	// Alarm types combine channels; first alarm output merges alarm 1 function
	always_comb begin
		alm_d = '0;
		for (int i = 0; i < HCA_NCH; i++) alm_d = alm_d | ch_alm[i];
		first_d = first_alarm_output_func_in | (|alm_d);
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tick_q   <= '0;
			hold_q   <= '0;
			pulse_q  <= '0;
			key_p_q  <= 1'b0;
			heat_q   <= 1'b0;
			armed_q  <= 1'b0;
			shorts_q <= 1'b0;
			level_q  <= HCA_OPER;
			en_q     <= HCA_EN_RESET;
			alm_q    <= '0;
			first_q  <= 1'b0;
		end else begin
			tick_q   <= tick_d;
			hold_q   <= hold_d;
			pulse_q  <= pulse_d;
			key_p_q  <= key_s_q;
			heat_q   <= heat_in;
			armed_q  <= armed_d;
			shorts_q <= shorts_d;
			level_q  <= level_d;
			en_q     <= en_d;
			alm_q    <= alm_d;
			first_q  <= first_d;
		end
	end

	assign level_out              = level_q;
	assign en_out                 = en_q;
	assign alarm_out              = alm_q;
	assign first_alarm_output_out = first_q;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	property p_long;
		level_q == HCA_OPER && long_go |=> level_q == HCA_INIT;
	endproperty
	a_long: assert property (p_long) else $error("long hold did not enter initial level");

	property p_pw;
		level_q == HCA_INIT && !step_go && pw_valid_in && pw_value_in == HCA_PASSWORD |=> level_q == HCA_ADV;
	endproperty
	a_pw: assert property (p_pw) else $error("password did not enter advanced level");

	property p_adv_gate;
		$rose(level_q == HCA_ADV) |-> $past(pw_valid_in && pw_value_in == HCA_PASSWORD && level_q == HCA_INIT);
	endproperty
	a_adv_gate: assert property (p_adv_gate) else $error("advanced level without password");

	property p_step;
		level_q == HCA_ADV && step_go |=> level_q == HCA_INIT ##1 level_q != HCA_OPER;
	endproperty
	a_step: assert property (p_step) else $error("advanced level step wrong");

	property p_adj;
		$rose(level_q == HCA_ADJ) |-> $past(level_q == HCA_OPER && shorts_q && hold_q < HCA_MS_W'(SHORT_MS));
	endproperty
	a_adj: assert property (p_adj) else $error("adjustment level entered wrongly");

	property p_or;
		first_alarm_output_func_in || ch_alm[0].heater_short_alarm || ch_alm[1].heater_open_alarm |=> first_q;
	endproperty
	a_or: assert property (p_or) else $error("first alarm output missed an alarm");

	property p_en;
		$changed(en_q) |-> $past(en_wr_in && level_q == HCA_ADV);
	endproperty
	a_en: assert property (p_en) else $error("enable changed outside advanced level");

	property p_skip;
		heat_in != heat_q |=> !on_ok && !off_ok;
	endproperty
	a_skip: assert property (p_skip) else $error("detection not skipped after edge");

	c_adv: cover property (level_q == HCA_INIT ##1 level_q == HCA_ADV);
	c_adj: cover property (level_q == HCA_OPER ##1 level_q == HCA_ADJ);
	c_first: cover property (!first_q ##1 first_q);

endmodule // hca_top

// *** test/hca_panel.sv ***
`timescale 1ns/10ps
module hca_panel
	import hca_pkg::*;
#(
	parameter int TICK = 4
) (
	input  wire logic                     clk_in,
	output logic                          key_out,
	output logic                          heat_out,
	output logic                          sample_out,
	output logic [HCA_NCH-1:0][15:0]      cur_out
);
	// Idle panel: key up, heater off, no valid reading on the lines
	initial begin
		key_out = 1'b0;
		heat_out = 1'b0;
		sample_out = 1'b0;
		cur_out = '1;
	end

	// Hold the key for whole ticks, then release long enough to rearm
	task automatic press(input int ticks);
		@(posedge clk_in);
		key_out <= 1'b1;
		repeat (ticks * TICK) @(posedge clk_in);
		key_out <= 1'b0;
		repeat (3 * TICK) @(posedge clk_in);
	endtask

	// Switch heating and let it stand for a number of ticks
	task automatic heat(input logic on, input int ticks);
		@(posedge clk_in);
		heat_out <= on;
		repeat (ticks * TICK) @(posedge clk_in);
	endtask

	// One reading; afterwards the lines carry garbage, not the old value
	task automatic sample(input logic [15:0] c0, input logic [15:0] c1);
		@(posedge clk_in);
		sample_out <= 1'b1;
		cur_out <= {c1, c0};
		@(posedge clk_in);
		sample_out <= 1'b0;
		cur_out <= ~{c1, c0};
		repeat (3) @(posedge clk_in);
	endtask
endmodule // hca_panel

// *** test/heater_current_alarm_test.sv ***
`timescale 1ns/10ps
module heater_current_alarm_test;
	import hca_pkg::*;
	localparam int       TICK = 2;
	localparam hca_thr_t DEF  = '{10'h032, 10'h014, 10'h0C8};
	logic                     clk_in = 1'b0;
	logic                     rstn_in;
	logic                     pw_valid_in;
	logic                     en_wr_in;
	logic                     first_alarm_output_func_in;
	logic [15:0]              pw_value_in;
	hca_alm_t                 en_data_in;
	hca_thr_t [HCA_NCH-1:0]   thr_in;
	logic                     level_key_in;
	logic                     heat_in;
	logic                     sample_in;
	logic [HCA_NCH-1:0][15:0] cur_in;
	hca_level_t               level_out;
	hca_alm_t                 en_out;
	hca_alm_t                 alarm_out;
	logic                     first_alarm_output_out;
	logic [HCA_NCH-1:0][15:0] heat_mon_out;
	logic [HCA_NCH-1:0][15:0] leak_mon_out;
	int                       mismatches = 0;
	int                       num_checks = 0;

	// Only the tick is shortened, so hold, step, short-press and pulse limits keep their real counts
	hca_top #(.TICK_CYCLES(TICK)) i_dut (
		.clk_in(clk_in), .rstn_in(rstn_in), .level_key_in(level_key_in), .pw_valid_in(pw_valid_in),
		.pw_value_in(pw_value_in), .en_wr_in(en_wr_in), .en_data_in(en_data_in), .heat_in(heat_in),
		.first_alarm_output_func_in(first_alarm_output_func_in), .sample_in(sample_in), .cur_in(cur_in), .thr_in(thr_in),
		.level_out(level_out), .en_out(en_out), .alarm_out(alarm_out),
		.first_alarm_output_out(first_alarm_output_out), .heat_mon_out(heat_mon_out), .leak_mon_out(leak_mon_out));

	hca_panel #(.TICK(TICK)) i_panel (.clk_in(clk_in), .key_out(level_key_in), .heat_out(heat_in),
		.sample_out(sample_in), .cur_out(cur_in));

	// 40 MHz clock
	always #12.5 clk_in = ~clk_in;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Let the edge updates land before looking
	task automatic settle(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic pulse_pw(input logic [15:0] v);
		@(posedge clk_in);
		pw_value_in <= v;
		pw_valid_in <= 1'b1;
		@(posedge clk_in);
		pw_valid_in <= 1'b0;
		settle(3);
	endtask

	task automatic write_en(input hca_alm_t v);
		@(posedge clk_in);
		en_data_in <= v;
		en_wr_in <= 1'b1;
		@(posedge clk_in);
		en_wr_in <= 1'b0;
		settle(4);
	endtask

	task automatic samp(input logic [15:0] c0, input logic [15:0] c1, input logic [2:0] exp);
		i_panel.sample(c0, c1);
		#1;
		chk(alarm_out, exp);
	endtask

	task automatic t_reset();
		chk(level_out, HCA_OPER);
		chk(en_out, HCA_EN_RESET);
		chk(alarm_out, 3'h0);
	endtask

	task automatic t_heat();
		i_panel.heat(1'b1, 120);
		samp(16'h001E, 16'h0064, 3'h4);
		chk(first_alarm_output_out, 1'b1);
		chk(heat_mon_out[0], 16'h001E);
		samp(16'h0226, 16'h0227, 3'h1);
		chk(heat_mon_out[0], 16'h0226);
		chk(heat_mon_out[1], 16'hFFFF);
		samp(16'h0064, 16'h0064, 3'h0);
		chk(first_alarm_output_out, 1'b0);
		@(posedge clk_in);
		first_alarm_output_func_in <= 1'b1;
		settle(3);
		chk(first_alarm_output_out, 1'b1);
		first_alarm_output_func_in <= 1'b0;
		// A short on-time must not judge the heater
		i_panel.heat(1'b0, 8);
		i_panel.heat(1'b1, 2);
		samp(16'h001E, 16'h0064, 3'h0);
		i_panel.heat(1'b1, 120);
		samp(16'h001E, 16'h0064, 3'h4);
		samp(16'h0064, 16'h0064, 3'h0);
	endtask

	task automatic t_short();
		i_panel.heat(1'b0, 120);
		samp(16'h001E, 16'h000A, 3'h2);
		chk(leak_mon_out[0], 16'h001E);
		chk(leak_mon_out[1], 16'h000A);
		samp(16'h000A, 16'h000A, 3'h0);
		i_panel.heat(1'b1, 8);
		i_panel.heat(1'b0, 2);
		samp(16'h001E, 16'h000A, 3'h0);
	endtask

	task automatic t_forced();
		@(posedge clk_in);
		thr_in[1] <= '0;
		settle(4);
		chk(alarm_out, 3'h3);
		thr_in[1] <= '{10'h1F4, 10'h1F4, 10'h1F4};
		settle(4);
		chk(alarm_out, 3'h4);
		thr_in[1] <= DEF;
		thr_in[0].short_thr <= 10'h001;
		i_panel.heat(1'b0, 120);
		// Channel 1 keeps its forced open verdict until its next qualified on-time sample
		samp(16'h0001, 16'h0000, 3'h4);
		samp(16'h0002, 16'h0000, 3'h6);
		thr_in[0].short_thr <= 10'h1F3;
		samp(16'h01F3, 16'h0000, 3'h4);
		thr_in[0] <= DEF;
	endtask

	task automatic t_levels();
		write_en(3'h0);
		chk(en_out, 3'h7);
		i_panel.press(3020);
		chk(level_out, HCA_INIT);
		pulse_pw(16'h00A9);
		chk(level_out, HCA_INIT);
		pulse_pw(HCA_PASSWORD);
		chk(level_out, HCA_ADV);
		thr_in[1] <= '0;
		write_en(3'h0);
		chk(en_out, 3'h0);
		chk(alarm_out, 3'h0);
		write_en(3'h2);
		chk(alarm_out, 3'h2);
		write_en(3'h7);
		thr_in[1] <= DEF;
		i_panel.press(1020);
		chk(level_out, HCA_INIT);
		i_panel.press(1020);
		chk(level_out, HCA_OPER);
		i_panel.press(2);
		chk(level_out, HCA_OPER);
		i_panel.press(2);
		#1;
		chk(level_out, HCA_ADJ);
	endtask

	task automatic print_verdict();
		if (mismatches == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Main sequence: reset for 8 cycles, then every scenario in turn
	initial begin
		rstn_in = 1'b0;
		pw_valid_in = 1'b0;
		en_wr_in = 1'b0;
		first_alarm_output_func_in = 1'b0;
		pw_value_in = 16'h0000;
		en_data_in = '0;
		thr_in = {DEF, DEF};
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
		settle(2);
		t_reset();
		t_heat();
		t_short();
		t_forced();
		t_levels();
		print_verdict();
	end

	// Watchdog: the real hold counts make the scenarios take about eleven thousand cycles
	initial begin
		repeat (30000) @(posedge clk_in);
		mismatches++;
		print_verdict();
	end
endmodule // heater_current_alarm_test
